// ### rtl/odac_pkg.sv
// Constants and types shared by the octal converter command logic.
package odac_pkg;
  // Channel count, code width and shift register length.
  localparam int NCH  = 8;
  localparam int DW   = 16;
  localparam int SR_W = 32;
  // Width of the decoded part of a frame: command, channel and data word.
  localparam int FRAME_W = 24;
  // Command codes.
  localparam logic [3:0] CMD_WR_IN      = 4'h0;
  localparam logic [3:0] CMD_UPD_N      = 4'h1;
  localparam logic [3:0] CMD_WR_UPD_ALL = 4'h2;
  localparam logic [3:0] CMD_WR_UPD_N   = 4'h3;
  localparam logic [3:0] CMD_PD_N       = 4'h4;
  localparam logic [3:0] CMD_PD_CHIP    = 4'h5;
  localparam logic [3:0] CMD_REF_INT    = 4'h6;
  localparam logic [3:0] CMD_REF_EXT    = 4'h7;
  localparam logic [3:0] CMD_NOP        = 4'hf;
  // Channel code that selects every channel.
  localparam logic [3:0] CHAN_ALL = 4'hf;
  // Codes loaded by power-up and clear.
  localparam logic [15:0] CODE_ZERO = 16'h0000;
  localparam logic [15:0] CODE_MID  = 16'h8000;
  // Cycles spent after reset before the level select is trusted.
  localparam logic [2:0] INIT_CYCLES = 3'h2;
  // Reset values of the shift register and the reference select.
  localparam logic [31:0] SR_RESET  = 32'h0000_0000;
  localparam logic        REF_RESET = 1'b0;

  typedef enum logic [2:0] {
    ST_INIT  = 3'b001,
    ST_IDLE  = 3'b010,
    ST_FRAME = 3'b100
  } odac_state_t;

  typedef struct packed {
    logic [3:0]  cmd;
    logic [3:0]  chan;
    logic [15:0] data;
  } odac_frame_t;

  typedef struct packed {
    logic       ref_external;
    logic       ref_powered_down;
    logic [7:0] chan_powered_down;
  } odac_status_t;
endpackage : odac_pkg

// ### rtl/odac_link.sv
// Serial-clock side shift register with the daisy-chain output.
`timescale 1ns/1ps
`default_nettype none
module odac_link #(
  parameter int SR_W = odac_pkg::SR_W
) (
  // Serial link
  input  wire logic            link_clk,
  input  wire logic            select_and_load_n,
  input  wire logic            serial_in,
  output logic                 serial_out,
  // Captured word towards the control clock
  output logic [SR_W-1:0]      shift_word
);
  typedef struct packed {
    logic [SR_W-1:0] sr;
  } odac_link_st_t;

  odac_link_st_t q;
  odac_link_st_t d;
  logic          out_q;

  always_comb
  begin
    d = q;
    if (!select_and_load_n)
    begin
      d.sr = {q.sr[SR_W-2:0], serial_in};
    end
  end

  always_ff @(posedge link_clk)
  begin
    q <= d;
  end

  // The top bit goes out on the falling edge so the next device sees it settled.
  always_ff @(negedge link_clk)
  begin
    out_q <= q.sr[SR_W-1];
  end

  assign serial_out = out_q;
  assign shift_word = q.sr;
endmodule : odac_link
`default_nettype wire

// ### rtl/odac_core.sv
// Command decode, channel registers and pin handling of the octal converter.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - While select is low, serial clock shifts input bits into the register.
// - Rising select stops shifting and executes the held command.
// - Host presents each input bit for capture on serial clock rise.
// - Frames of 24 or 32 bits are both accepted and decoded.
// - Output repeats each input bit 32 rising edges later, on a falling edge.
// - Serial output is always driven, never high impedance.
// - Update pin falling with select high copies all inputs to outputs.
// - Update pin falling with select low defers the copy until select rises.
// - Update pin low powers up all channels regardless of select.
// - Update pin low at select rise suppresses any power-down command.
// - Clear low with level select low zeroes all channel registers.
// - Clear low with level select high loads mid-scale everywhere.
// - After power-up registers hold zero or mid-scale per level select.
// - Command 0000 writes the addressed input register only.
// - Command 0001 updates and powers up the addressed channel.
// - Command 0010 writes addressed input, then updates and powers up all.
// - Command 0011 writes and updates the addressed channel, powering it up.
// - Command 0100 powers down the addressed channels; 0101 everything and reference.
// - Command 0110 selects internal reference; 0111 selects external.
// - Command 1111 does nothing; unassigned codes must not be sent.
// - Channel codes 0 to 7 pick one channel; 1111 picks all.
// - Internal reference is active after power-up.
// - Frame is command, channel, then 16-bit data word MSB first.
// - 32-bit frame has 8 leading ignored bits; non-writes ignore data.
module odac_core #(
  parameter int NCH = odac_pkg::NCH,
  parameter int DW  = odac_pkg::DW
) (
  // Clock and reset
  input  wire logic                       mclk,
  input  wire logic                       sys_rst,
  // Serial link
  input  wire logic                       link_clk,
  input  wire logic                       select_and_load_n,
  input  wire logic                       serial_in,
  output logic                            serial_out,
  // Control pins
  input  wire logic                       async_update_n,
  input  wire logic                       async_clear_n,
  input  wire logic                       reset_level_select,
  // Converter side
  output logic [NCH-1:0][DW-1:0]          dac_code,
  output odac_pkg::odac_status_t          status
);
  typedef struct packed {
    odac_pkg::odac_state_t  st;
    logic [2:0]             init_cnt;
    logic [1:0]             load_n_sync;
    logic [1:0]             upd_sync;
    logic [1:0]             clear_sync;
    logic [1:0]             sel_sync;
    logic                   upd_prev;
    logic                   pend;
    logic                   ref_pd_chip;
    logic [NCH-1:0][DW-1:0] in_reg;
    logic [NCH-1:0][DW-1:0] out_reg;
    odac_pkg::odac_status_t stat;
  } odac_core_st_t;

  odac_core_st_t         q;
  odac_core_st_t         d;
  logic [odac_pkg::SR_W-1:0] shift_word;
  odac_pkg::odac_frame_t frm;
  logic [DW-1:0]         lvl;
  logic [NCH-1:0]        hit;
  logic                  upd_fall;
  logic                  exec;
  logic                  sup;
  logic                  wr;

  odac_link #(
    .SR_W (odac_pkg::SR_W)
  ) u_link (
    .link_clk          (link_clk),
    .select_and_load_n (select_and_load_n),
    .serial_in         (serial_in),
    .serial_out        (serial_out),
    .shift_word        (shift_word)
  );

  always_comb
  begin
    // The word is read only once select has been high for two cycles, so the
    // serial clock has stopped and every bit is settled.
    frm = odac_pkg::odac_frame_t'(shift_word[odac_pkg::FRAME_W-1:0]);
    lvl = q.sel_sync[1] ? odac_pkg::CODE_MID : odac_pkg::CODE_ZERO;
    hit = '0;
    if (frm.chan == odac_pkg::CHAN_ALL)
    begin
      hit = '1;
    end
    else if (!frm.chan[3])
    begin
      hit[frm.chan[2:0]] = 1'b1;
    end
    upd_fall = q.upd_prev && !q.upd_sync[1];
    exec = (q.st == odac_pkg::ST_FRAME) && q.load_n_sync[1];
    sup = !q.upd_sync[1];
    wr = (frm.cmd == odac_pkg::CMD_WR_IN) || (frm.cmd == odac_pkg::CMD_WR_UPD_ALL) ||
         (frm.cmd == odac_pkg::CMD_WR_UPD_N);
    d = q;
    d.load_n_sync = {q.load_n_sync[0], select_and_load_n};
    d.upd_sync = {q.upd_sync[0], async_update_n};
    d.clear_sync = {q.clear_sync[0], async_clear_n};
    d.sel_sync = {q.sel_sync[0], reset_level_select};
    d.upd_prev = q.upd_sync[1];
    case (q.st)
      odac_pkg::ST_INIT:
      begin
        if (q.init_cnt == odac_pkg::INIT_CYCLES)
        begin
          d.in_reg = {NCH{lvl}};
          d.out_reg = {NCH{lvl}};
          d.st = odac_pkg::ST_IDLE;
        end
        else
        begin
          d.init_cnt = q.init_cnt + 3'h1;
        end
      end
      odac_pkg::ST_IDLE:
      begin
        if (upd_fall && q.load_n_sync[1])
        begin
          d.out_reg = q.in_reg;
        end
        else if (upd_fall)
        begin
          d.pend = 1'b1;
        end
        if (!q.load_n_sync[1])
        begin
          d.st = odac_pkg::ST_FRAME;
        end
      end
      odac_pkg::ST_FRAME:
      begin
        if (upd_fall)
        begin
          d.pend = 1'b1;
        end
        if (exec)
        begin
          for (int i = 0; i < NCH; i++)
          begin
            if (hit[i] && wr)
            begin
              d.in_reg[i] = frm.data;
            end
          end
          case (frm.cmd)
            odac_pkg::CMD_UPD_N, odac_pkg::CMD_WR_UPD_N:
            begin
              for (int i = 0; i < NCH; i++)
              begin
                if (hit[i])
                begin
                  d.out_reg[i] = d.in_reg[i];
                  d.stat.chan_powered_down[i] = 1'b0;
                end
              end
              if (hit != '0)
              begin
                d.ref_pd_chip = 1'b0;
              end
            end
            odac_pkg::CMD_WR_UPD_ALL:
            begin
              d.out_reg = d.in_reg;
              d.stat.chan_powered_down = '0;
              d.ref_pd_chip = 1'b0;
            end
            odac_pkg::CMD_PD_N:
            begin
              if (!sup)
              begin
                d.stat.chan_powered_down = q.stat.chan_powered_down | hit;
              end
            end
            odac_pkg::CMD_PD_CHIP:
            begin
              if (!sup)
              begin
                d.stat.chan_powered_down = '1;
                d.ref_pd_chip = 1'b1;
              end
            end
            odac_pkg::CMD_REF_INT:
            begin
              d.stat.ref_external = 1'b0;
              d.ref_pd_chip = 1'b0;
            end
            odac_pkg::CMD_REF_EXT:
            begin
              if (!sup)
              begin
                d.stat.ref_external = 1'b1;
              end
            end
            default:
            begin
              d.pend = d.pend;
            end
          endcase
          // A deferred or still-low update pin copies every channel after the command.
          if (q.pend || sup)
          begin
            d.out_reg = d.in_reg;
            d.pend = 1'b0;
          end
          d.st = odac_pkg::ST_IDLE;
        end
      end
      default:
      begin
        d.st = odac_pkg::ST_INIT;
      end
    endcase
    if (sup && (q.st != odac_pkg::ST_INIT))
    begin
      d.stat.chan_powered_down = '0;
      d.ref_pd_chip = 1'b0;
    end
    // Clear is a level and overrides any input or output register written in the same cycle.
    if (!q.clear_sync[1] && (q.st != odac_pkg::ST_INIT))
    begin
      d.in_reg = {NCH{lvl}};
      d.out_reg = {NCH{lvl}};
    end
    d.stat.ref_powered_down = d.stat.ref_external | d.ref_pd_chip;
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      q.st <= odac_pkg::ST_INIT;
      q.init_cnt <= 3'h0;
      q.load_n_sync <= 2'h3;
      q.upd_sync <= 2'h3;
      q.clear_sync <= 2'h3;
      q.sel_sync <= 2'h0;
      q.upd_prev <= 1'b1;
      q.pend <= 1'b0;
      q.ref_pd_chip <= 1'b0;
      q.in_reg <= '0;
      q.out_reg <= '0;
      q.stat.ref_external <= odac_pkg::REF_RESET;
      q.stat.ref_powered_down <= 1'b0;
      q.stat.chan_powered_down <= 8'h00;
    end
    else
    begin
      q <= d;
    end
  end

  assign dac_code = q.out_reg;
  assign status = q.stat;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  logic quiet;
  assign quiet = q.upd_sync[1] && !q.pend && q.clear_sync[1];

  AST_EXEC_RETURNS_IDLE: assert property (exec |=> q.st == odac_pkg::ST_IDLE)
    else $error("Execution did not return to idle.");

  AST_WRITE_INPUT_ONLY: assert property (
    exec && frm.cmd == odac_pkg::CMD_WR_IN && !frm.chan[3] && quiet
    |=> q.in_reg[$past(frm.chan[2:0])] == $past(frm.data) && $stable(q.out_reg))
    else $error("Write to input register went wrong.");

  AST_UPDATE_ONE: assert property (
    exec && frm.cmd == odac_pkg::CMD_UPD_N && !frm.chan[3] && q.clear_sync[1]
    |=> q.out_reg[$past(frm.chan[2:0])] == $past(q.in_reg[frm.chan[2:0]])
        && !q.stat.chan_powered_down[$past(frm.chan[2:0])])
    else $error("Single channel update went wrong.");

  AST_WRITE_UPDATE_ALL: assert property (
    exec && frm.cmd == odac_pkg::CMD_WR_UPD_ALL && q.clear_sync[1]
    |=> q.out_reg == q.in_reg && q.stat.chan_powered_down == 8'h00)
    else $error("Write and update all went wrong.");

  AST_WRITE_UPDATE_ONE: assert property (
    exec && frm.cmd == odac_pkg::CMD_WR_UPD_N && !frm.chan[3] && q.clear_sync[1]
    |=> q.out_reg[$past(frm.chan[2:0])] == $past(frm.data))
    else $error("Write and update of one channel went wrong.");

  AST_POWER_DOWN_ONE: assert property (
    exec && frm.cmd == odac_pkg::CMD_PD_N && !frm.chan[3] && q.upd_sync[1]
    |=> q.stat.chan_powered_down[$past(frm.chan[2:0])])
    else $error("Channel power-down was not taken.");

  AST_REF_EXTERNAL: assert property (
    exec && frm.cmd == odac_pkg::CMD_REF_EXT && q.upd_sync[1]
    |=> q.stat.ref_external ##1 q.stat.ref_powered_down)
    else $error("External reference select went wrong.");

  AST_NOP_STILL: assert property (
    exec && frm.cmd == odac_pkg::CMD_NOP && quiet
    |=> $stable(q.out_reg) && $stable(q.in_reg) && $stable(q.stat))
    else $error("No-operation changed state.");

  AST_UPD_HIGH_SELECT: assert property (
    upd_fall && q.load_n_sync[1] && q.st == odac_pkg::ST_IDLE && q.clear_sync[1]
    |=> q.out_reg == $past(q.in_reg))
    else $error("Update pin did not copy input registers.");

  AST_UPD_DEFER: assert property (
    upd_fall && q.st == odac_pkg::ST_FRAME && !q.load_n_sync[1]
    |=> q.pend)
    else $error("Update during frame was not deferred.");

  AST_UPD_POWER_UP: assert property (
    !q.upd_sync[1] && q.st != odac_pkg::ST_INIT |=> q.stat.chan_powered_down == 8'h00)
    else $error("Update pin low did not power up channels.");

  AST_PD_SUPPRESSED: assert property (
    exec && !q.upd_sync[1] && frm.cmd != odac_pkg::CMD_REF_INT
    |=> q.stat.chan_powered_down == 8'h00 && $stable(q.stat.ref_external))
    else $error("Power-down was not suppressed.");

  AST_CLEAR_LEVEL: assert property (
    !q.clear_sync[1] && q.st != odac_pkg::ST_INIT
    |=> q.out_reg == {NCH{$past(lvl)}} && q.in_reg == {NCH{$past(lvl)}})
    else $error("Clear did not load the selected level.");

  AST_POWER_UP_LEVEL: assert property (
    q.st == odac_pkg::ST_INIT && q.init_cnt == odac_pkg::INIT_CYCLES
    |=> q.out_reg == {NCH{$past(lvl)}} && q.st == odac_pkg::ST_IDLE)
    else $error("Power-up level not loaded.");

  AST_REF_DEFAULT: assert property (
    q.st == odac_pkg::ST_INIT |-> !q.stat.ref_external && !q.stat.ref_powered_down)
    else $error("Internal reference not active after reset.");

  COV_WRITE: cover property (exec && frm.cmd == odac_pkg::CMD_WR_IN);
  COV_DEFER: cover property (q.pend ##[1:200] exec);
  COV_CLEAR: cover property (!q.clear_sync[1] && q.sel_sync[1]);
  COV_CHIP_DOWN: cover property (exec && frm.cmd == odac_pkg::CMD_PD_CHIP && q.upd_sync[1]);
endmodule : odac_core
`default_nettype wire

// ### verification/odac_host_model.sv
// Host model that drives command frames onto the serial link.
`timescale 1ns/1ps
`default_nettype none
module odac_host_model #(
  parameter int HALF_NS = 16
) (
  // Serial link
  output logic      link_clk,
  output logic      select_and_load_n,
  output logic      serial_in,
  input  wire logic serial_out
);
  logic [31:0] echo_q;

  initial
  begin
    link_clk          = 1'b0;
    select_and_load_n = 1'b1;
    serial_in         = 1'b0;
    echo_q            = 32'h0000_0000;
  end

  // The clock stands still outside frames; tail delays the select rise.
  task automatic send_frame(input logic [31:0] word, input int nbits, input int tail);
    select_and_load_n = 1'b0;
    #(HALF_NS);
    for (int i = nbits - 1; i >= 0; i--)
    begin
      serial_in = word[i];
      #(HALF_NS);
      link_clk = 1'b1;
      echo_q   = {echo_q[30:0], serial_out};
      #(HALF_NS);
      link_clk = 1'b0;
    end
    #(HALF_NS + tail);
    select_and_load_n = 1'b1;
    // A released data line shows the inverse of its last bit.
    serial_in = ~serial_in;
  endtask : send_frame
endmodule : odac_host_model
`default_nettype wire

// ### verification/tb_top.sv
// Self-checking bench for the octal converter command logic.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic                   mclk;
  logic                   sys_rst;
  logic                   link_clk;
  logic                   select_and_load_n;
  logic                   serial_in;
  logic                   serial_out;
  logic                   async_update_n;
  logic                   async_clear_n;
  logic                   reset_level_select;
  logic [7:0][15:0]       dac_code;
  odac_pkg::odac_status_t status;
  logic [7:0][15:0]       in_m;
  logic [7:0][15:0]       out_m;
  logic [7:0]             pd_m;
  logic                   ext_m;
  logic                   chip_m;
  int                     fails;
  int                     checked;

  odac_core i_odac_core (
    .mclk(mclk), .sys_rst(sys_rst), .link_clk(link_clk),
    .select_and_load_n(select_and_load_n), .serial_in(serial_in), .serial_out(serial_out),
    .async_update_n(async_update_n), .async_clear_n(async_clear_n),
    .reset_level_select(reset_level_select), .dac_code(dac_code), .status(status)
  );

  odac_host_model i_odac_host_model (
    .link_clk(link_clk), .select_and_load_n(select_and_load_n),
    .serial_in(serial_in), .serial_out(serial_out)
  );

  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic give_verdict();
    $display("checked %0d, fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : give_verdict

  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic check_all();
    check(dac_code, out_m);
    check(128'(status), 128'({ext_m, ext_m | chip_m, pd_m}));
  endtask : check_all

  task automatic do_reset(input logic lvl);
    @(negedge mclk);
    sys_rst            = 1'b1;
    reset_level_select = lvl;
    repeat (2) @(negedge mclk);
    sys_rst = 1'b0;
    repeat (6) @(negedge mclk);
    in_m   = {8{lvl ? odac_pkg::CODE_MID : odac_pkg::CODE_ZERO}};
    out_m  = in_m;
    pd_m   = 8'h00;
    ext_m  = odac_pkg::REF_RESET;
    chip_m = 1'b0;
  endtask : do_reset

  task automatic pulse_update();
    @(negedge mclk);
    async_update_n = 1'b0;
    repeat (4) @(negedge mclk);
    async_update_n = 1'b1;
    repeat (4) @(negedge mclk);
    out_m  = in_m;
    pd_m   = 8'h00;
    chip_m = 1'b0;
  endtask : pulse_update

  // Mode 1 pulses the update pin inside the frame, mode 2 holds it low across it.
  task automatic cmd(input logic [3:0] c, input logic [3:0] a, input logic [15:0] d,
                     input int n, input int mode);
    logic [7:0] sel;
    sel = (a == odac_pkg::CHAN_ALL) ? 8'hff : (a < 4'h8) ? 8'h01 << a[2:0] : 8'h00;
    @(negedge mclk);
    if (mode == 2)
    begin
      async_update_n = 1'b0;
      repeat (5) @(negedge mclk);
    end
    fork
      i_odac_host_model.send_frame({8'hc3, c, a, d}, n, 0);
      if (mode == 1)
      begin
        repeat (10) @(negedge mclk);
        pulse_update();
      end
    join
    for (int i = 0; i < 8; i++)
      if (sel[i] && (c == 4'h0 || c == 4'h2 || c == 4'h3))
        in_m[i] = d;
    case (c)
      4'h1, 4'h3:
      begin
        for (int i = 0; i < 8; i++)
          if (sel[i])
          begin
            out_m[i] = in_m[i];
            pd_m[i]  = 1'b0;
          end
        chip_m = 1'b0;
      end
      4'h2:
      begin
        out_m  = in_m;
        pd_m   = 8'h00;
        chip_m = 1'b0;
      end
      4'h4: if (mode != 2) pd_m = pd_m | sel;
      4'h5:
        if (mode != 2)
        begin
          pd_m   = 8'hff;
          chip_m = 1'b1;
        end
      4'h6:
      begin
        ext_m  = 1'b0;
        chip_m = 1'b0;
      end
      4'h7: if (mode != 2) ext_m = 1'b1;
      default: ;
    endcase
    if (mode != 0)
    begin
      out_m  = in_m;
      pd_m   = 8'h00;
      chip_m = 1'b0;
    end
    repeat (8) @(negedge mclk);
    async_update_n = 1'b1;
  endtask : cmd

  task automatic clear(input logic lvl);
    @(negedge mclk);
    reset_level_select = lvl;
    repeat (3) @(negedge mclk);
    async_clear_n = 1'b0;
    repeat (5) @(negedge mclk);
    in_m  = {8{lvl ? odac_pkg::CODE_MID : odac_pkg::CODE_ZERO}};
    out_m = in_m;
    check_all();
    async_clear_n = 1'b1;
    repeat (4) @(negedge mclk);
  endtask : clear

  initial
  begin
    #200_000;
    fails++;
    $display("[ERR] %0t watchdog expired", $time);
    give_verdict();
  end

  initial
  begin
    sys_rst            = 1'b1;
    async_update_n     = 1'b1;
    async_clear_n      = 1'b1;
    reset_level_select = 1'b0;
    fails              = 0;
    checked            = 0;
    do_reset(1'b0);
    check_all();
    $display("done: power-up");
    cmd(4'h0, 4'h2, 16'h1234, 24, 0);
    check_all();
    cmd(4'h1, 4'h2, 16'hffff, 32, 0);
    check_all();
    cmd(4'h0, 4'h0, 16'haaaa, 24, 0);
    cmd(4'h0, 4'h7, 16'h5555, 32, 0);
    cmd(4'h2, 4'h1, 16'h0f0f, 24, 0);
    check_all();
    cmd(4'h3, 4'h5, 16'hc3c3, 32, 0);
    check_all();
    $display("done: writes");
    cmd(4'h4, 4'h3, 16'h0000, 24, 0);
    check_all();
    cmd(4'h4, 4'h9, 16'h0000, 24, 0);
    check_all();
    cmd(4'h5, 4'h0, 16'h0000, 24, 0);
    check_all();
    cmd(4'h6, 4'h0, 16'h0000, 24, 0);
    check_all();
    cmd(4'h7, 4'h0, 16'h0000, 32, 0);
    check_all();
    cmd(4'h1, 4'hf, 16'h0000, 24, 0);
    check_all();
    cmd(4'hf, 4'h3, 16'hdead, 24, 0);
    check_all();
    cmd(4'h6, 4'h0, 16'h0000, 24, 0);
    $display("done: power and reference");
    cmd(4'h0, 4'h4, 16'h4444, 24, 0);
    cmd(4'h4, 4'hf, 16'h0000, 24, 0);
    pulse_update();
    check_all();
    cmd(4'h0, 4'h6, 16'hbeef, 24, 1);
    check_all();
    cmd(4'h4, 4'h0, 16'h0000, 24, 2);
    check_all();
    cmd(4'h7, 4'h0, 16'h0000, 24, 2);
    check_all();
    $display("done: update pin");
    clear(1'b0);
    cmd(4'h1, 4'hf, 16'h0000, 24, 0);
    check_all();
    clear(1'b1);
    cmd(4'h1, 4'hf, 16'h0000, 24, 0);
    check_all();
    $display("done: clear");
    cmd(4'hf, 4'h0, 16'h1234, 32, 0);
    i_odac_host_model.send_frame(32'h5aff_0000, 32, 8);
    check(128'(i_odac_host_model.echo_q), 128'(32'hc3f0_1234));
    check(128'(serial_out === 1'b0 || serial_out === 1'b1), 128'(1'b1));
    repeat (8) @(negedge mclk);
    $display("done: daisy chain");
    do_reset(1'b1);
    check_all();
    $display("done: mid-scale power-up");
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
